// file: include/ira_pkg.sv
// Constants and types for the I2C register access slave
// How it works
// - Device acknowledges each host byte it accepts, host samples
// - Write burst holds at most eight data bytes
// - Reads start at current address counter
// - Written pointer byte loads the address counter
// - Dummy write, repeated START, then read accepted
// - Every byte shifts most significant bit first
// - First byte after START is address+direction
// - Answer only own address, default 68h
// - Counter rolls from FFh to 00h
// - Address mismatch: ignore bus until next START
// - Reading pair upper byte latches both bytes
// - In a write, byte after address byte is the pointer
package ira_pkg;
	localparam logic [6:0] SLAVE_ADDR_DEF = 7'h68;
	localparam int MAX_WR_BYTES_DEF = 8;
	localparam logic [7:0] ADDR_CNT_RST = 8'h00;
	localparam logic [7:0] PAIR_MSB_ACC = 8'h10;
	localparam logic [7:0] PAIR_MSB_CUR = 8'h16;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int SYNC_WIDTH = 2;
	localparam int SYNC_SCL = 0;
	localparam int SYNC_SDA = 1;

	typedef enum logic [3:0] {
		IRA_IDLE = 4'b0000,
		IRA_ADDR = 4'b0001,
		IRA_ADDR_ACK = 4'b0010,
		IRA_PTR = 4'b0011,
		IRA_PTR_ACK = 4'b0100,
		IRA_WDATA = 4'b0101,
		IRA_WDATA_ACK = 4'b0110,
		IRA_RDATA = 4'b0111,
		IRA_RACK = 4'b1000,
		IRA_IGNORE = 4'b1001
	} ira_state_t;
endpackage : ira_pkg

// file: verilog/ira_sync.sv
// Two-flop pin synchroniser with edge detection per bit
`timescale 1ns/10ps
`default_nettype none
module ira_sync #(
	parameter int WIDTH = 2
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	initial begin
		if (WIDTH < 1) $error("ira_sync: WIDTH must be at least 1");
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			logic prev_q;
			logic meta_d;
			logic sync_d;
			logic prev_d;
			always_comb begin
				meta_d = pin_in[i];
				sync_d = meta_q;
				prev_d = sync_q;
			end
			// Idle bus level is high
			always_ff @(posedge sys_clk or posedge reset) begin
				if (reset) begin
					meta_q <= 1'b1;
					sync_q <= 1'b1;
					prev_q <= 1'b1;
				end else if (clk_en) begin
					meta_q <= meta_d;
					sync_q <= sync_d;
					prev_q <= prev_d;
				end
			end
			assign level[i] = sync_q;
			assign rise[i] = sync_q & ~prev_q;
			assign fall[i] = ~sync_q & prev_q;
		end
	endgenerate
endmodule : ira_sync
`default_nettype wire

// file: verilog/ira_slave.sv
// I2C slave engine giving a host access to a byte-addressed register space
`timescale 1ns/10ps
`default_nettype none
module ira_slave #(
	parameter logic [6:0] SLAVE_ADDR = ira_pkg::SLAVE_ADDR_DEF,
	parameter int MAX_WR_BYTES = ira_pkg::MAX_WR_BYTES_DEF
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic [7:0] rd_next_data,
	output logic wr_stb,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic busy
);
	initial begin
		if (MAX_WR_BYTES < 1 || MAX_WR_BYTES > 255) $error("ira_slave: MAX_WR_BYTES out of range");
	end

	logic [1:0] lvl;
	logic [1:0] rise;
	logic [1:0] fall;

	ira_sync #(
		.WIDTH(ira_pkg::SYNC_WIDTH)
	) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.clk_en(clk_en),
		.pin_in({sda_in, scl_in}),
		.level(lvl),
		.rise(rise),
		.fall(fall)
	);

	logic scl_h;
	logic sda_v;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_h = lvl[ira_pkg::SYNC_SCL];
	assign sda_v = lvl[ira_pkg::SYNC_SDA];
	assign scl_rise = rise[ira_pkg::SYNC_SCL];
	assign scl_fall = fall[ira_pkg::SYNC_SCL];
	assign start_det = scl_h & fall[ira_pkg::SYNC_SDA];
	assign stop_det = scl_h & rise[ira_pkg::SYNC_SDA];

	ira_pkg::ira_state_t state_q, state_d;
	logic [7:0] shreg_q, shreg_d;
	logic [2:0] bit_q, bit_d;
	logic got_q, got_d;
	logic rw_q, rw_d;
	logic [7:0] addr_q, addr_d;
	logic [7:0] wcnt_q, wcnt_d;
	logic oe_q, oe_d;
	logic [7:0] hold_q, hold_d;
	logic [7:0] hold_addr_q, hold_addr_d;
	logic hold_vld_q, hold_vld_d;
	logic wr_stb_q, wr_stb_d;
	logic [7:0] wr_addr_q, wr_addr_d;
	logic [7:0] wr_data_q, wr_data_d;

	// Byte presented for the current counter value
	logic [7:0] rd_byte;
	logic held_hit;
	assign held_hit = hold_vld_q && (hold_addr_q == addr_q);
	assign rd_byte = held_hit ? hold_q : rd_data;

	// Loads the next read byte and drives its top bit
	task automatic load_read();
		shreg_d = rd_byte;
		oe_d = ~rd_byte[7];
		addr_d = addr_q + 8'h01;
		bit_d = 3'h0;
		got_d = 1'b0;
		state_d = ira_pkg::IRA_RDATA;
		if (!held_hit && (addr_q == ira_pkg::PAIR_MSB_ACC || addr_q == ira_pkg::PAIR_MSB_CUR)) begin
			hold_d = rd_next_data;
			hold_addr_d = addr_q + 8'h01;
			hold_vld_d = 1'b1;
		end
	endtask : load_read

	always_comb begin
		state_d = state_q;
		shreg_d = shreg_q;
		bit_d = bit_q;
		got_d = got_q;
		rw_d = rw_q;
		addr_d = addr_q;
		wcnt_d = wcnt_q;
		oe_d = oe_q;
		hold_d = hold_q;
		hold_addr_d = hold_addr_q;
		hold_vld_d = hold_vld_q;
		wr_stb_d = 1'b0;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		if (start_det) begin
			// Any START, repeated or not, begins an address byte
			state_d = ira_pkg::IRA_ADDR;
			bit_d = 3'h0;
			got_d = 1'b0;
			oe_d = 1'b0;
			hold_vld_d = 1'b0;
		end else if (stop_det) begin
			state_d = ira_pkg::IRA_IDLE;
			oe_d = 1'b0;
			hold_vld_d = 1'b0;
		end else if (scl_rise) begin
			unique case (state_q)
				ira_pkg::IRA_ADDR, ira_pkg::IRA_PTR, ira_pkg::IRA_WDATA: begin
					shreg_d = {shreg_q[6:0], sda_v};
					bit_d = bit_q + 3'h1;
					got_d = (bit_q == ira_pkg::LAST_BIT);
				end
				ira_pkg::IRA_RDATA: begin
					bit_d = bit_q + 3'h1;
					got_d = (bit_q == ira_pkg::LAST_BIT);
				end
				ira_pkg::IRA_RACK: begin
					got_d = ~sda_v;
				end
				ira_pkg::IRA_IDLE, ira_pkg::IRA_ADDR_ACK, ira_pkg::IRA_PTR_ACK,
				ira_pkg::IRA_WDATA_ACK, ira_pkg::IRA_IGNORE: begin
				end
				default: begin
					state_d = ira_pkg::IRA_IGNORE;
				end
			endcase
		end else if (scl_fall) begin
			unique case (state_q)
				ira_pkg::IRA_ADDR: begin
					if (got_q) begin
						got_d = 1'b0;
						if (shreg_q[7:1] == SLAVE_ADDR) begin
							rw_d = shreg_q[0];
							oe_d = 1'b1;
							state_d = ira_pkg::IRA_ADDR_ACK;
						end else begin
							state_d = ira_pkg::IRA_IGNORE;
						end
					end
				end
				ira_pkg::IRA_ADDR_ACK: begin
					oe_d = 1'b0;
					if (rw_q) begin
						load_read();
					end else begin
						bit_d = 3'h0;
						state_d = ira_pkg::IRA_PTR;
					end
				end
				ira_pkg::IRA_PTR: begin
					if (got_q) begin
						got_d = 1'b0;
						addr_d = shreg_q;
						wcnt_d = 8'h00;
						hold_vld_d = 1'b0;
						oe_d = 1'b1;
						state_d = ira_pkg::IRA_PTR_ACK;
					end
				end
				ira_pkg::IRA_PTR_ACK, ira_pkg::IRA_WDATA_ACK: begin
					oe_d = 1'b0;
					bit_d = 3'h0;
					state_d = ira_pkg::IRA_WDATA;
				end
				ira_pkg::IRA_WDATA: begin
					if (got_q) begin
						got_d = 1'b0;
						if (wcnt_q < 8'(MAX_WR_BYTES)) begin
							wr_stb_d = 1'b1;
							wr_addr_d = addr_q;
							wr_data_d = shreg_q;
							addr_d = addr_q + 8'h01;
							wcnt_d = wcnt_q + 8'h01;
							oe_d = 1'b1;
							state_d = ira_pkg::IRA_WDATA_ACK;
						end else begin
							// Excess byte left unacknowledged and dropped
							state_d = ira_pkg::IRA_IGNORE;
						end
					end
				end
				ira_pkg::IRA_RDATA: begin
					if (got_q) begin
						got_d = 1'b0;
						oe_d = 1'b0;
						state_d = ira_pkg::IRA_RACK;
					end else begin
						shreg_d = {shreg_q[6:0], 1'b0};
						oe_d = ~shreg_q[6];
					end
				end
				ira_pkg::IRA_RACK: begin
					if (got_q) begin
						load_read();
					end else begin
						oe_d = 1'b0;
						state_d = ira_pkg::IRA_IGNORE;
					end
				end
				ira_pkg::IRA_IDLE, ira_pkg::IRA_IGNORE: begin
					oe_d = 1'b0;
				end
				default: begin
					oe_d = 1'b0;
					state_d = ira_pkg::IRA_IGNORE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_q <= ira_pkg::IRA_IDLE;
			shreg_q <= 8'h00;
			bit_q <= 3'h0;
			got_q <= 1'b0;
			rw_q <= 1'b0;
			addr_q <= ira_pkg::ADDR_CNT_RST;
			wcnt_q <= 8'h00;
			oe_q <= 1'b0;
			hold_q <= 8'h00;
			hold_addr_q <= 8'h00;
			hold_vld_q <= 1'b0;
			wr_stb_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
		end else if (clk_en) begin
			state_q <= state_d;
			shreg_q <= shreg_d;
			bit_q <= bit_d;
			got_q <= got_d;
			rw_q <= rw_d;
			addr_q <= addr_d;
			wcnt_q <= wcnt_d;
			oe_q <= oe_d;
			hold_q <= hold_d;
			hold_addr_q <= hold_addr_d;
			hold_vld_q <= hold_vld_d;
			wr_stb_q <= wr_stb_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
		end
	end

	// Open drain: the pin is only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = oe_q;
	assign rd_addr = addr_q;
	assign wr_stb = wr_stb_q;
	assign wr_addr = wr_addr_q;
	assign wr_data = wr_data_q;
	assign busy = (state_q != ira_pkg::IRA_IDLE) && (state_q != ira_pkg::IRA_IGNORE);
endmodule : ira_slave
`default_nettype wire

// file: verif/ira_slave_sva.sv
// Port checker for the register access slave
`timescale 1ns/10ps
`default_nettype none
module ira_slave_sva (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic [7:0] rd_addr,
	input wire logic wr_stb,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	chk_oe_clk_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("drive changed with clock high");
	chk_oe_hold: assert property ($rose(sda_oe) |-> sda_oe [*8])
		else $error("drive too short");
	chk_stb_pulse: assert property (wr_stb |=> !wr_stb)
		else $error("strobe too long");
	chk_stb_count: assert property (wr_stb |=> rd_addr == wr_addr + 8'h01)
		else $error("counter not advanced");
	chk_wr_held: assert property ($changed(wr_addr) || $changed(wr_data) |-> wr_stb)
		else $error("write fields moved");
	chk_stb_busy: assert property (wr_stb |-> busy)
		else $error("write while idle");
	chk_idle_quiet: assert property (!busy && !$past(busy) |-> !sda_oe)
		else $error("drive while idle");
	chk_idle_addr: assert property (!busy |=> $stable(rd_addr))
		else $error("counter moved while idle");
	chk_stop_idle: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] !busy)
		else $error("busy after stop");
	cover property (wr_stb);
	cover property ($fell(busy));
	cover property ($rose(sda_oe) ##1 busy);
endmodule : ira_slave_sva
bind ira_slave ira_slave_sva chk (.sys_clk(sys_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
	.sda_oe(sda_oe), .rd_addr(rd_addr), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
`default_nettype wire

// file: verif/ira_host.sv
// Host bus master model driving the link pins
`timescale 1ns/10ps
`default_nettype none
module ira_host (
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Data set while clock low
	task automatic bitx(input logic b, output logic r);
		sda_low = ~b;
		#40 scl = 1'b1;
		#40 r = sda;
		#40 scl = 1'b0;
		#40;
	endtask : bitx
	task automatic start;
		sda_low = 1'b0;
		#40 scl = 1'b1;
		#80 sda_low = 1'b1;
		#80 scl = 1'b0;
		#40;
	endtask : start
	task automatic stop;
		sda_low = 1'b1;
		#40 scl = 1'b1;
		#80 sda_low = 1'b0;
		#80;
	endtask : stop
	task automatic wbyte(input logic [7:0] d, output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], a);
		bitx(1'b1, a);
	endtask : wbyte
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic x;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		// Released line is a NACK on the last byte
		bitx(last, x);
	endtask : rbyte
endmodule : ira_host
`default_nettype wire

// file: verif/ira_slave_tb.sv
// Self-checking bench for the register access slave
`timescale 1ns/10ps
`default_nettype none
module ira_slave_tb;
	logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, scl, sda_low, sda_oe, sda_out, wr_stb, busy, a;
	logic [7:0] mem [256];
	logic [7:0] rd_addr, wr_addr, wr_data, d;
	logic [7:0] rows [3][2] = '{'{8'h00, 8'hA5}, '{8'h3C, 8'h5A}, '{8'hFF, 8'h81}};
	wire logic sda = ~sda_low & (~sda_oe | sda_out);
	int failures = 0, n_checks = 0, cyc = 0;
	ira_host host (.scl(scl), .sda_low(sda_low), .sda(sda));
	ira_slave uut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .rd_addr(rd_addr), .rd_data(mem[rd_addr]),
		.rd_next_data(mem[rd_addr + 8'h01]), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
	initial forever #10 sys_clk = ~sys_clk;
	initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'hC3;
	always @(posedge sys_clk) if (wr_stb === 1'b1) mem[wr_addr] <= wr_data;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic chk(input logic [7:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic hdr(input logic rw);
		host.start();
		host.wbyte({ira_pkg::SLAVE_ADDR_DEF, rw}, a);
		chk(a, 8'h00, "addr ack");
	endtask : hdr
	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 reset = 1'b0;
		chk({busy, sda_oe, wr_stb}, 8'h00, "reset flags");
		chk(rd_addr, ira_pkg::ADDR_CNT_RST, "reset addr");
		repeat (4) @(posedge sys_clk);
		#1;
		foreach (rows[i]) begin
			hdr(1'b0);
			host.wbyte(rows[i][0], a);
			host.wbyte(rows[i][1], a);
			chk(a, 8'h00, "data ack");
			host.stop();
			hdr(1'b0);
			host.wbyte(rows[i][0], a);
			hdr(1'b1);
			host.rbyte(1'b1, d);
			host.stop();
			chk(d, rows[i][1], "readback");
		end
		hdr(1'b0);
		host.wbyte(8'hFC, a);
		for (int k = 0; k < 9; k++) begin
			host.wbyte(8'hE0 + 8'(k), a);
			chk(a, 8'(k == 8), "burst ack");
		end
		host.stop();
		hdr(1'b0);
		host.wbyte(8'hFC, a);
		hdr(1'b1);
		for (int k = 0; k < 9; k++) begin
			host.rbyte(k == 8, d);
			chk(d, k < 8 ? 8'hE0 + 8'(k) : 8'h04 ^ 8'hC3, "burst read");
		end
		host.stop();
		hdr(1'b1);
		host.rbyte(1'b1, d);
		chk(d, 8'h05 ^ 8'hC3, "counter read");
		host.rbyte(1'b1, d);
		chk(d, 8'hFF, "released");
		host.stop();
		hdr(1'b0);
		host.wbyte(8'h16, a);
		hdr(1'b1);
		host.rbyte(1'b0, d);
		chk(d, 8'h16 ^ 8'hC3, "pair upper");
		mem[8'h17] = 8'h00;
		host.rbyte(1'b1, d);
		host.stop();
		chk(d, 8'h17 ^ 8'hC3, "pair latch");
		host.start();
		host.wbyte({ira_pkg::SLAVE_ADDR_DEF ^ 7'h01, 1'b0}, a);
		chk(a, 8'h01, "foreign ack");
		host.wbyte(8'h20, a);
		host.stop();
		chk({6'h00, a, busy}, 8'h02, "foreign ignored");
		chk(rd_addr, 8'h18, "foreign addr");
		// Frozen engine must not answer its own address
		clk_en = 1'b0;
		host.start();
		host.wbyte({ira_pkg::SLAVE_ADDR_DEF, 1'b1}, a);
		clk_en = 1'b1;
		host.stop();
		chk({6'h00, a, busy}, 8'h02, "frozen no ack");
		chk(rd_addr, 8'h18, "frozen addr");
		reset = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 chk({7'h00, busy}, 8'h00, "mid reset busy");
		chk(rd_addr, ira_pkg::ADDR_CNT_RST, "mid reset addr");
		reset = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		hdr(1'b1);
		host.rbyte(1'b1, d);
		host.stop();
		chk(d, 8'hE4, "read after reset");
		give_verdict();
	end
endmodule : ira_slave_tb
`default_nettype wire
